/* sfc_device.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - top/bottom set: lower region doubles, high codes all
// - complement only: whole, lower part, then nothing
// - both set: all, upper from block n, nothing
// - drop program/erase touching protected blocks
// - latch serial_in on rising clock, MSB first
// - host shifts MSB first, valid at rise
// - frame starts with one opcode byte
// - host raises select after last input bit
// - read opcodes continue with output phase
// - select may rise anywhere during output
// - write commands need whole bytes at select rise
// - partial program byte: nothing, latch kept
// - short program or release-with-id ignored
// - program needs address plus one data byte
// - erase needs exact address width
// - array access ignored while internal cycle runs
// - write enable first; latch cleared on completion
// - write_in_progress set during internal cycle
module sfc_device #(
  parameter int BUSY_CYCLES = sfc_pkg::PROG_CYC,  // internal cycle length
  parameter logic [7:0] DEVICE_ID = 8'h5A         // arbitrary id value
) (
  input wire logic sys_clk_i,   // system clock
  input wire logic rstn_i,      // async reset, active low
  sfc_if.dev link,              // serial link
  output logic exec_valid_o,    // one-cycle pulse: program/erase starts
  output logic [7:0] exec_op_o, // opcode of started command
  output logic [31:0] exec_addr_o, // target address of started command
  output logic wip_o,           // write_in_progress
  output logic wel_o,           // write_enable_latch
  output logic addr4_o,         // 32-bit addressing active
  output logic powered_down_o   // deep power-down active
);
  localparam int CW = $clog2(BUSY_CYCLES + 1);

  logic [2:0] sclk_s;       // clock synchroniser and edge stage
  logic [2:0] cs_s;         // select synchroniser and edge stage
  logic [1:0] mosi_s;       // data synchroniser
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bit_reg;      // bits in current byte
  logic [8:0] nbyte_reg;    // whole bytes received, saturating
  logic [7:0] sreg_reg;     // input shifter
  logic [7:0] op_reg;       // opcode of the frame
  logic [31:0] addr_reg;    // collected address
  logic [7:0] data1_reg;    // first byte after opcode
  logic [7:0] shift_next;
  logic [7:0] cur_op;
  logic byte_done;
  logic [8:0] alen;         // address bytes for the mode
  logic out_arm_reg;        // output phase active
  logic [2:0] obit_reg;     // output bit position
  logic [7:0] osreg_reg;    // output shifter
  logic miso_reg;
  logic [7:0] out_byte;
  logic out_start;
  logic wel_reg;
  logic wip_reg;
  logic [CW-1:0] busy_reg;  // internal cycle countdown
  logic busy_end;
  logic addr4_reg;
  logic pd_reg;
  logic cmp_reg;
  logic tb_reg;
  logic [3:0] bp_reg;
  logic exec_valid_reg;
  logic [7:0] exec_op_reg;
  logic [31:0] exec_addr_reg;
  logic [10:0] lo;          // protected block range
  logic [10:0] hi;
  logic [10:0] sz;
  logic none;
  logic [10:0] blk;
  logic hit;
  logic whole;
  logic ok_base;            // frame ended cleanly, device free
  logic prog_ok;
  logic erase_ok;
  logic exec_go;
  logic stwr_go;
  logic write_enable_cmd_go;
  logic wrdi_go;
  logic [7:0] status;

  // two-flop synchronisers plus one edge stage
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
    end
  end

  assign sclk_rise = sclk_s[1] && !sclk_s[2] && !cs_s[1];
  assign sclk_fall = !sclk_s[1] && sclk_s[2] && !cs_s[1];
  assign cs_fall = !cs_s[1] && cs_s[2];
  assign cs_rise = cs_s[1] && !cs_s[2];
  assign shift_next = {sreg_reg[6:0], mosi_s[1]};
  assign byte_done = sclk_rise && (bit_reg == 3'h7);
  assign cur_op = (nbyte_reg == 9'h000) ? shift_next : op_reg;
  assign alen = addr4_reg ? sfc_pkg::LEN_A4 : sfc_pkg::LEN_A3;

  // input framing: bit and byte counts, opcode, address
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_reg <= 3'h0;
      nbyte_reg <= 9'h000;
      sreg_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_reg <= 32'h0000_0000;
      data1_reg <= 8'h00;
    end else if (cs_fall) begin
      bit_reg <= 3'h0;
      nbyte_reg <= 9'h000;
      addr_reg <= 32'h0000_0000;
    end else if (sclk_rise) begin
      sreg_reg <= shift_next;
      bit_reg <= bit_reg + 3'h1;
      if (byte_done) begin
        if (nbyte_reg == 9'h000) begin
          op_reg <= shift_next;
        end else if (nbyte_reg <= alen) begin
          addr_reg <= {addr_reg[23:0], shift_next};
        end
        if (nbyte_reg == 9'h001) begin
          data1_reg <= shift_next;
        end
        if (nbyte_reg != 9'h1FF) begin
          nbyte_reg <= nbyte_reg + 9'h001;
        end
      end
    end
  end

  // which opcodes turn to output after their input part
  always_comb begin
    out_start = 1'b0;
    if (byte_done && !(pd_reg && cur_op != sfc_pkg::OP_PREL)) begin
      unique case (cur_op)
        sfc_pkg::OP_STRD, sfc_pkg::OP_EXRD: begin
          out_start = (nbyte_reg == 9'h000);
        end
        sfc_pkg::OP_PREL: begin
          out_start = (nbyte_reg + 9'h001 == sfc_pkg::LEN_ID);
        end
        sfc_pkg::OP_READ: begin
          out_start = (nbyte_reg == alen) && !wip_reg;
        end
        default: out_start = 1'b0;
      endcase
    end
  end

  assign status = {cmp_reg, tb_reg, bp_reg, wel_reg, wip_reg};

  // byte sent back for the frame's opcode
  always_comb begin
    unique case (op_reg)
      sfc_pkg::OP_STRD: out_byte = status;
      sfc_pkg::OP_EXRD: out_byte = {7'h00, addr4_reg};
      sfc_pkg::OP_PREL: out_byte = DEVICE_ID;
      default: out_byte = 8'hFF;  // no array behind this front end
    endcase
  end

  // output phase, changed on falling clock, repeats until select rises
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_arm_reg <= 1'b0;
      obit_reg <= 3'h0;
      osreg_reg <= 8'h00;
      miso_reg <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      out_arm_reg <= 1'b0;
    end else if (out_start) begin
      out_arm_reg <= 1'b1;
      obit_reg <= 3'h0;
    end else if (sclk_fall && out_arm_reg) begin
      obit_reg <= obit_reg + 3'h1;
      if (obit_reg == 3'h0) begin
        miso_reg <= out_byte[7];
        osreg_reg <= {out_byte[6:0], 1'b0};
      end else begin
        miso_reg <= osreg_reg[7];
        osreg_reg <= {osreg_reg[6:0], 1'b0};
      end
    end
  end

  // protected block range from the protect bits
  always_comb begin
    none = 1'b0;
    lo = 11'h000;
    hi = sfc_pkg::BLK_LAST;
    sz = 11'h001 << (bp_reg - 4'h1);
    if (bp_reg == 4'h0) begin
      none = !cmp_reg;
    end else if (bp_reg > sfc_pkg::BP_MAX_RANGE) begin
      none = cmp_reg;
    end else begin
      unique case ({cmp_reg, tb_reg})
        2'b00: lo = sfc_pkg::BLK_TOTAL - sz;
        2'b01: hi = sz - 11'h001;
        2'b10: hi = sfc_pkg::BLK_LAST - sz;
        2'b11: lo = sz;
      endcase
    end
  end

  assign blk = {1'b0, addr_reg[sfc_pkg::BLK_MSB:sfc_pkg::BLK_LSB]};
  assign hit = !none && (blk >= lo) && (blk <= hi);

  // end-of-frame decisions
  assign whole = (bit_reg == 3'h0);
  assign ok_base = cs_rise && whole && !wip_reg && !pd_reg;
  assign prog_ok = (op_reg == sfc_pkg::OP_PGM || op_reg == sfc_pkg::OP_QPGM)
    && (nbyte_reg >= alen + 9'h002);
  assign erase_ok = (op_reg == sfc_pkg::OP_SECE || op_reg == sfc_pkg::OP_HBLE
    || op_reg == sfc_pkg::OP_BLKE) && (nbyte_reg == alen + 9'h001);
  assign exec_go = ok_base && wel_reg && (prog_ok || erase_ok) && !hit;
  assign stwr_go = ok_base && wel_reg && (op_reg == sfc_pkg::OP_STWR)
    && (nbyte_reg >= sfc_pkg::LEN_SR);
  assign write_enable_cmd_go = ok_base && (op_reg == sfc_pkg::OP_WRITE_ENABLE_CMD) && (nbyte_reg == sfc_pkg::LEN_OP);
  assign wrdi_go = ok_base && (op_reg == sfc_pkg::OP_WRDI) && (nbyte_reg == sfc_pkg::LEN_OP);
  assign busy_end = wip_reg && (busy_reg == '0);

  // internal cycle timer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wip_reg <= 1'b0;
      busy_reg <= '0;
    end else if (exec_go || stwr_go) begin
      wip_reg <= 1'b1;
      busy_reg <= CW'(BUSY_CYCLES - 1);
    end else if (busy_end) begin
      wip_reg <= 1'b0;
    end else if (wip_reg) begin
      busy_reg <= busy_reg - 1'b1;
    end
  end

  // write enable latch
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wel_reg <= 1'b0;
    end else if (write_enable_cmd_go) begin
      wel_reg <= 1'b1;
    end else if (wrdi_go || busy_end) begin
      wel_reg <= 1'b0;
    end
  end

  // protect bits written by the status write
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp_reg <= 1'b0;
      tb_reg <= 1'b0;
      bp_reg <= 4'h0;
    end else if (stwr_go) begin
      cmp_reg <= data1_reg[sfc_pkg::SR_CMP];
      tb_reg <= data1_reg[sfc_pkg::SR_TB];
      bp_reg <= data1_reg[sfc_pkg::SR_BP_LSB +: 4];
    end
  end

  // addressing mode and power-down
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr4_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else if (cs_rise && whole && !wip_reg) begin
      if (pd_reg) begin
        // only release wakes; release with id needs its dummies
        if (op_reg == sfc_pkg::OP_PREL && (nbyte_reg == sfc_pkg::LEN_OP
            || nbyte_reg >= sfc_pkg::LEN_ID)) begin
          pd_reg <= 1'b0;
        end
      end else if (nbyte_reg == sfc_pkg::LEN_OP) begin
        if (op_reg == sfc_pkg::OP_A4EN) begin
          addr4_reg <= 1'b1;
        end else if (op_reg == sfc_pkg::OP_A4EX) begin
          addr4_reg <= 1'b0;
        end else if (op_reg == sfc_pkg::OP_PDWN) begin
          pd_reg <= 1'b1;
        end
      end
    end
  end

  // started-command report
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_valid_reg <= 1'b0;
      exec_op_reg <= 8'h00;
      exec_addr_reg <= 32'h0000_0000;
    end else begin
      exec_valid_reg <= exec_go;
      if (exec_go) begin
        exec_op_reg <= op_reg;
        exec_addr_reg <= addr_reg;
      end
    end
  end

  assign link.miso = miso_reg;
  assign exec_valid_o = exec_valid_reg;
  assign exec_op_o = exec_op_reg;
  assign exec_addr_o = exec_addr_reg;
  assign wip_o = wip_reg;
  assign wel_o = wel_reg;
  assign addr4_o = addr4_reg;
  assign powered_down_o = pd_reg;
endmodule
`default_nettype wire

/* sfc_pkg.sv */
package sfc_pkg;
  // clock figures
  localparam int SYS_CLK_NS = 25;        // system clock period
  localparam int SCLK_PERIOD_NS = 200;   // serial clock period made by the host
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
  localparam int PROG_TIME_NS = 500000;  // internal write cycle time
  localparam int PROG_CYC = PROG_TIME_NS / SYS_CLK_NS;
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;    // write_enable_cmd
  localparam logic [7:0] OP_WRDI = 8'h04;    // write disable
  localparam logic [7:0] OP_STRD = 8'h05;    // status_read_cmd
  localparam logic [7:0] OP_STWR = 8'h01;    // status write
  localparam logic [7:0] OP_PGM = 8'h02;     // page_program_cmd
  localparam logic [7:0] OP_QPGM = 8'h32;    // quad_page_program_cmd
  localparam logic [7:0] OP_SECE = 8'h20;    // sector_erase_cmd
  localparam logic [7:0] OP_HBLE = 8'h52;    // half_block_erase_cmd
  localparam logic [7:0] OP_BLKE = 8'hD8;    // block_erase_cmd
  localparam logic [7:0] OP_READ = 8'h03;    // array read
  localparam logic [7:0] OP_EXRD = 8'hC8;    // address-mode read
  localparam logic [7:0] OP_A4EN = 8'hB7;    // enter 32-bit addressing
  localparam logic [7:0] OP_A4EX = 8'hE9;    // exit 32-bit addressing
  localparam logic [7:0] OP_PDWN = 8'hB9;    // deep power-down
  localparam logic [7:0] OP_PREL = 8'hAB;    // powerdown_release_id_cmd
  // status byte layout
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_TB = 6;
  localparam int SR_CMP = 7;
  // byte counts
  localparam logic [8:0] LEN_OP = 9'h001;    // opcode only
  localparam logic [8:0] LEN_A3 = 9'h003;    // 24-bit address
  localparam logic [8:0] LEN_A4 = 9'h004;    // 32-bit address
  localparam logic [8:0] LEN_ID = 9'h004;    // opcode plus three dummies
  localparam logic [8:0] LEN_SR = 9'h002;    // opcode plus status byte
  // protection geometry, 64 KB blocks
  localparam int BLK_LSB = 16;
  localparam int BLK_MSB = 25;
  localparam logic [10:0] BLK_TOTAL = 11'h400;
  localparam logic [10:0] BLK_LAST = 11'h3FF;
  localparam logic [3:0] BP_MAX_RANGE = 4'hA;  // codes above protect all or none
  // host buffer entry: {read, last, byte}
  localparam int ENT_W = 10;
  localparam int ENT_RD = 9;
  localparam int ENT_LAST = 8;
endpackage

/* sfc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfc_if;
  logic sclk;   // serial clock, made by the host
  logic cs_n;   // chip select, active low
  logic mosi;   // serial_in of the device
  logic miso;   // serial out of the device
  modport dev(input sclk, input cs_n, input mosi, output miso);
  modport host(output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

/* sfc_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,          // system clock
  input wire logic rstn_i,             // async reset, active low
  input wire logic in_valid_i,         // write side valid
  output logic in_ready_o,             // write side ready (not full)
  input wire logic [W-1:0] in_data_i,  // write data
  output logic out_valid_o,            // read side valid (not empty)
  input wire logic out_ready_i,        // read side ready
  output logic [W-1:0] out_data_o      // head entry
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];  // storage
  logic [PW-1:0] wr_reg;      // write pointer
  logic [PW-1:0] rd_reg;      // read pointer
  logic [PW:0] cnt_reg;       // occupancy
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_reg];

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* sfc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_host #(
  parameter int HALF_DIV = sfc_pkg::SCLK_HALF_CYC  // system cycles per clock half
) (
  input wire logic sys_clk_i,      // system clock
  input wire logic rstn_i,         // async reset, active low
  sfc_if.host link,                // serial link
  input wire logic tx_valid_i,     // byte offered
  output logic tx_ready_o,         // byte accepted
  input wire logic [7:0] tx_data_i, // byte to send
  input wire logic tx_last_i,      // byte ends the frame
  input wire logic tx_read_i,      // capture the byte clocked in meanwhile
  output logic rx_valid_o,         // one-cycle pulse: read byte ready
  output logic [7:0] rx_data_o,    // read byte
  output logic busy_o              // frame in progress
);
  localparam int DW = $clog2(2 * HALF_DIV + 1);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_WAIT = 3'b011,
    H_END = 3'b100
  } sfc_hst_e;

  sfc_hst_e state_reg;
  logic [DW-1:0] div_reg;      // clock divider
  logic [2:0] bit_reg;         // bit in byte
  logic [7:0] tx_reg;          // output shifter
  logic [7:0] rx_reg;          // input shifter
  logic rd_reg;
  logic last_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic mosi_reg;
  logic rx_valid_reg;
  logic [7:0] rx_data_reg;
  logic [1:0] miso_s;          // two-flop synchroniser
  logic bo_valid;
  logic [sfc_pkg::ENT_W-1:0] bo_data;
  logic load;
  logic half_end;

  // two-entry buffer; an empty buffer mid-frame parks the clock low
  sfc_buf #(.W(sfc_pkg::ENT_W), .DEPTH(2)) u_buf (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i({tx_read_i, tx_last_i, tx_data_i}),
    .out_valid_o(bo_valid),
    .out_ready_i(load),
    .out_data_o(bo_data)
  );

  assign load = bo_valid && (state_reg == H_IDLE || state_reg == H_WAIT);
  assign half_end = (div_reg == DW'(HALF_DIV - 1));

  // miso synchroniser
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_s <= 2'h0;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  // frame sequencer and clock divider
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= H_IDLE;
      div_reg <= '0;
      bit_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      last_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else begin
      rx_valid_reg <= 1'b0;
      if (load) begin
        // new byte: select low, first bit out before the rise
        tx_reg <= {bo_data[6:0], 1'b0};
        mosi_reg <= bo_data[7];
        rd_reg <= bo_data[sfc_pkg::ENT_RD];
        last_reg <= bo_data[sfc_pkg::ENT_LAST];
        cs_n_reg <= 1'b0;
        bit_reg <= 3'h0;
        div_reg <= '0;
        state_reg <= H_LOW;
      end else begin
        unique case (state_reg)
          H_IDLE, H_WAIT: begin
            div_reg <= '0;
          end
          H_LOW: begin
            div_reg <= half_end ? '0 : div_reg + 1'b1;
            if (half_end) begin
              sclk_reg <= 1'b1;
              state_reg <= H_HIGH;
            end
          end
          H_HIGH: begin
            div_reg <= half_end ? '0 : div_reg + 1'b1;
            if (half_end) begin
              // sample at the fall, the device changes later
              sclk_reg <= 1'b0;
              rx_reg <= {rx_reg[6:0], miso_s[1]};
              if (bit_reg == 3'h7) begin
                rx_valid_reg <= rd_reg;
                rx_data_reg <= {rx_reg[6:0], miso_s[1]};
                state_reg <= last_reg ? H_END : H_WAIT;
              end else begin
                bit_reg <= bit_reg + 3'h1;
                mosi_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                state_reg <= H_LOW;
              end
            end
          end
          H_END: begin
            // select rises half a clock after the last bit, then stays high
            div_reg <= div_reg + 1'b1;
            if (half_end) begin
              cs_n_reg <= 1'b1;
            end
            if (div_reg == DW'(2 * HALF_DIV - 1)) begin
              state_reg <= H_IDLE;
            end
          end
          default: state_reg <= H_IDLE;
        endcase
      end
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  assign rx_valid_o = rx_valid_reg;
  assign rx_data_o = rx_data_reg;
  assign busy_o = (state_reg != H_IDLE);
endmodule
`default_nettype wire

/* sfc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_checker (
  input wire logic sys_clk_i, // system clock
  input wire logic rstn_i, // reset, active low
  input wire logic sclk, // serial clock
  input wire logic cs_n, // select, active low
  input wire logic mosi, // host to device
  input wire logic miso // device to host
);
  logic sclk_d; // last serial clock level
  logic [2:0] rise_cnt; // rising edges in frame, mod 8
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // edge finder and bit counter for the frame
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d <= 1'b0;
      rise_cnt <= 3'h0;
    end else begin
      sclk_d <= sclk;
      if (cs_n) begin
        rise_cnt <= 3'h0;
      end else if (sclk && !sclk_d) begin
        rise_cnt <= rise_cnt + 3'h1;
      end
    end
  end
  // one high half of four cycles, then low
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  // clock held low after select falls
  sequence s_lead;
    !sclk [*4];
  endsequence
  a_clock_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high with select off");
  a_high_phase_len: assert property ($rose(sclk) |-> s_high)
    else $error("serial clock high phase wrong");
  a_rise_in_frame: assert property ($rose(sclk) |-> $past(!cs_n, 4))
    else $error("clock rise too soon after select");
  a_select_lead: assert property ($fell(cs_n) |-> s_lead)
    else $error("clock moved during lead time");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select gap too short");
  a_mosi_hold_high: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_hold_high: assert property (!cs_n && sclk && sclk_d |-> $stable(miso))
    else $error("device data moved while clock high");
  a_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt == 3'h0)
    else $error("select rose off a byte boundary");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0; // system clock
  logic rstn_i = 1'b0; // reset, active low
  logic tx_valid = 1'b0, tx_last = 1'b0, tx_read = 1'b0; // host user strobes
  logic [7:0] tx_data = 8'h00; // byte offered
  logic tx_ready, rx_valid, busy, ex_v, write_in_progress, write_enable_latch, a4, pd; // design outputs
  logic [7:0] rx_data, ex_op; // read byte, started opcode
  logic [31:0] ex_addr, seed = 32'hC9AB8E7F; // started address, random state
  logic [39:0] exq[$]; // started commands seen
  int rxq[$]; // read bytes seen
  int err_count = 0, samples_checked = 0; // verdict counters
  int m_sr = 0, m_wel = 0, m_busy = 0, m_a4 = 0, m_pd = 0; // reference state
  sfc_if lnk();
  // internal cycle outlasts one long frame; id value is arbitrary
  sfc_device #(.BUSY_CYCLES(1000), .DEVICE_ID(8'h3C)) i_sfc_device(.sys_clk_i, .rstn_i, .link(lnk),
    .exec_valid_o(ex_v), .exec_op_o(ex_op), .exec_addr_o(ex_addr), .wip_o(write_in_progress),
    .wel_o(write_enable_latch), .addr4_o(a4), .powered_down_o(pd));
  sfc_host i_sfc_host(.sys_clk_i, .rstn_i, .link(lnk), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_read_i(tx_read), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy));
  sfc_checker i_sfc_checker(.sys_clk_i, .rstn_i, .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso(lnk.miso));
  // clock
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // capture read bytes and command starts
  always @(posedge sys_clk_i) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (ex_v === 1'b1) exq.push_back({ex_op, ex_addr});
  end
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    samples_checked++;
    if (exp !== got) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // bounded wait for busy (0) or wip (1) to drop
  task automatic wait_low(bit sel);
    int n = 0;
    while ((sel ? write_in_progress : busy) !== 1'b0) begin
      @(negedge sys_clk_i);
      if (++n > 5000) begin
        chk("wait", 0, 1);
        give_verdict();
      end
    end
  endtask
  // protected block set from the status bits
  function automatic bit prot(int sr, int blk);
    int c = (sr >> 2) & 15, n;
    n = (c == 0) ? 0 : (c > 10) ? 1024 : (1 << (c - 1)); // region size in blocks
    if (!sr[7]) return sr[6] ? blk < n : blk >= 1024 - n;
    return sr[6] ? blk >= n : blk < 1024 - n;
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  // one byte through the two-entry buffer
  task automatic put(int d, bit l, bit r);
    int n = 0;
    @(negedge sys_clk_i);
    tx_valid = 1'b1;
    tx_data = d[7:0];
    tx_last = l;
    tx_read = r;
    while (tx_ready !== 1'b1) begin
      @(negedge sys_clk_i);
      if (++n > 5000) begin
        chk("ready", 1, 0);
        give_verdict();
      end
    end
    @(posedge sys_clk_i);
  endtask
  // reference decision at select rise, then compare
  task automatic model(int q[$]);
    int op = q[0], al = m_a4 ? 4 : 3, ad = 0, n = q.size();
    bit go = 0;
    for (int i = 1; i <= al && i < n; i++) ad = (ad << 8) | q[i];
    if (m_pd) begin
      if (op == 'hAB && (n == 1 || n >= 4)) m_pd = 0;
    end else if (m_busy == 0) begin
      case (op)
        'h06: if (n == 1) m_wel = 1;
        'h04: if (n == 1) m_wel = 0;
        'hB7: m_a4 = 1;
        'hE9: m_a4 = 0;
        'hB9: if (n == 1) m_pd = 1;
        'h01: if (n == 2 && m_wel) begin
          m_sr = q[1] & 'hFC;
          m_busy = 1;
        end
        'h02, 'h32: go = n >= al + 2;
        'h20, 'h52, 'hD8: go = n == al + 1;
        default: go = 0;
      endcase
    end
    go = go && m_wel && !prot(m_sr, (ad >> 16) & 'h3FF);
    chk("starts", go, exq.size());
    if (exq.size() > 0) chk("start", {op[7:0], ad}, exq.pop_front());
    if (go) m_busy = 1;
    chk("wel", m_wel, write_enable_latch);
    chk("wip", m_busy, write_in_progress);
    chk("a4", m_a4, a4);
    chk("pd", m_pd, pd);
  endtask
  task automatic frame(int q[$], int nrd);
    foreach (q[i]) put(q[i], i == q.size() - 1 && nrd == 0, 0);
    for (int i = 0; i < nrd; i++) put(0, i == nrd - 1, 1);
    @(negedge sys_clk_i);
    tx_valid = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    wait_low(0);
    repeat (6) @(negedge sys_clk_i);
    model(q);
  endtask
  // let the internal cycle finish
  task automatic idle;
    if (m_busy) begin
      wait_low(1);
      m_busy = 0;
      m_wel = 0;
      chk("wel", 0, write_enable_latch);
    end
  endtask
  task automatic status;
    frame('{'h05}, 2);
    chk("reads", 2, rxq.size());
    while (rxq.size() > 0) chk("status", m_sr | m_wel << 1 | m_busy, rxq.pop_front());
  endtask
  // main sequence
  initial begin
    int q[$];
    repeat (10) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    status();
    frame('{'h06}, 0);
    status();
    $display("test reset and latch done");
    for (int k = 0; k < 28; k++) begin
      seed = lfsr(seed);
      frame('{'h06}, 0);
      frame('{'h01, seed[7:0]}, 0);
      status();
      idle();
      frame('{seed[8] ? 'hB7 : 'hE9}, 0);
      frame('{'hC8}, 1);
      chk("mode reads", 1, rxq.size());
      chk("mode", m_a4, rxq.pop_front());
      frame('{'h06}, 0);
      q = '{k % 4 == 0 ? 'h20 : k % 4 == 1 ? 'hD8 : k % 4 == 2 ? 'h02 : 'h52};
      for (int i = 0; i < (m_a4 ? 4 : 3) + seed[10:9]; i++) q.push_back(seed[31 - 8 * (i % 4) -: 8]);
      frame(q, 0);
      frame(q, 0);
      idle();
      $display("test %0d done", k);
    end
    frame('{'h06}, 0);
    frame('{'h04}, 0);
    frame('{'hB9}, 0);
    frame('{'h06}, 0);
    frame('{'hAB, 0, 0, 0}, 1);
    chk("id reads", 1, rxq.size());
    chk("id", 'h3C, rxq.pop_front());
    $display("test power-down done");
    give_verdict();
  end
endmodule
`default_nettype wire
